// ==== include/pcmu_params.svh ====
// Purpose: constants for the packed compare / multiply / or unit
// Assumes: included by bare name from the unit and the testbench top
// Notes:   opcodes are the second opcode byte after the 0F escape
`ifndef PCMU_PARAMS_SVH
`define PCMU_PARAMS_SVH

// ==========================================================================
// opcode bytes
`define PCMU_OP_ESCAPE     8'h0F
`define PCMU_OP_GT_BYTE    8'h64
`define PCMU_OP_GT_WORD    8'h65
`define PCMU_OP_GT_DWORD   8'h66
`define PCMU_OP_MUL_SUM    8'hF5
`define PCMU_OP_MUL_UPPER  8'hE5
`define PCMU_OP_MUL_LOWER  8'hD5
`define PCMU_OP_OR         8'hEB

// ==========================================================================
// widths, limits and fault vectors
`define PCMU_DATA_W        64
`define PCMU_REAL_LIMIT    32'h0000_FFFF
`define PCMU_OPND_BYTES    32'h0000_0008
`define PCMU_USER_CPL      2'h3
`define PCMU_VEC_UD        8'h06
`define PCMU_VEC_NM        8'h07
`define PCMU_VEC_SS        8'h0C
`define PCMU_VEC_GP        8'h0D
`define PCMU_VEC_PF        8'h0E
`define PCMU_VEC_MF        8'h10
`define PCMU_VEC_AC        8'h11
`define PCMU_RESULT_RESET  64'h0000_0000_0000_0000

`endif

// ==== include/pcmu_pkg.sv ====
// Purpose: types shared by the packed compare / multiply / or unit
// Assumes: nothing beyond the params header
// Notes:   fault kinds are listed in priority order, highest first, save SS which outranks GP
package pcmu_pkg;

    // ======================================================================
    // operation selected by the opcode byte
    typedef enum logic [2:0] {
        PCMU_OP_NONE  = 3'b000,
        PCMU_OP_GTB   = 3'b001,
        PCMU_OP_GTW   = 3'b010,
        PCMU_OP_GTD   = 3'b011,
        PCMU_OP_MSUM  = 3'b100,
        PCMU_OP_MUPP  = 3'b101,
        PCMU_OP_MLOW  = 3'b110,
        PCMU_OP_BOR   = 3'b111
    } pcmu_op_e;

    // ======================================================================
    // fault kinds reported beside the result
    typedef enum logic [3:0] {
        PCMU_FLT_NONE  = 4'b0000,
        PCMU_FLT_UD    = 4'b0001,
        PCMU_FLT_NM    = 4'b0010,
        PCMU_FLT_MF    = 4'b0011,
        PCMU_FLT_INT13 = 4'b0100,
        PCMU_FLT_GP    = 4'b0101,
        PCMU_FLT_SS    = 4'b0110,
        PCMU_FLT_PF    = 4'b0111,
        PCMU_FLT_AC    = 4'b1000
    } pcmu_fault_e;

    typedef logic [63:0] pcmu_word_t;

endpackage

// ==== include/pcmu_opnd_if.sv ====
// Purpose: operand bundle between the top and its lane datapath
// Assumes: single clock, purely combinational traffic
// Notes:   the top drives operands, the lanes return the compare and multiply results
`timescale 1ns/10ps
interface pcmu_opnd_if;
    import pcmu_pkg::*;
    pcmu_word_t dstVal;
    pcmu_word_t srcVal;
    pcmu_word_t gtByte;
    pcmu_word_t gtWord;
    pcmu_word_t gtDword;
    pcmu_word_t mulSum;
    pcmu_word_t mulUpper;
    pcmu_word_t mulLower;

    modport top (output dstVal, output srcVal, input gtByte, input gtWord,
                 input gtDword, input mulSum, input mulUpper, input mulLower);
    modport lanes (input dstVal, input srcVal, output gtByte, output gtWord,
                   output gtDword, output mulSum, output mulUpper, output mulLower);
endinterface

// ==== verilog/pcmu_word_lane.sv ====
// Purpose: one 16-bit lane: signed product and signed greater-than
// Assumes: operands stable for the cycle they are used
// Notes:   instanced four times by the datapath
`timescale 1ns/10ps
module pcmu_word_lane (
    input  wire logic [15:0] dstWord,
    input  wire logic [15:0] srcWord,
    output logic      [31:0] product,
    output logic             greater
);
    // ======================================================================
    // signed product; the low half equals the unsigned low half
    assign product = 32'($signed(dstWord) * $signed(srcWord));
    assign greater = $signed(dstWord) > $signed(srcWord);
endmodule // pcmu_word_lane

// ==== verilog/pcmu_lanes.sv ====
// Purpose: combinational element datapath of the unit
// Assumes: operands come through the interface
// Notes:   no carries cross element boundaries
`timescale 1ns/10ps
module pcmu_lanes (
    pcmu_opnd_if.lanes bus
);
    import pcmu_pkg::*;

    logic [31:0] prod [4];
    logic [3:0]  wordGt;
    logic [7:0]  byteGt;
    logic [1:0]  dwordGt;

    // ======================================================================
    // word lanes and byte/dword compares, each element on its own
    for (genvar i = 0; i < 4; i++) begin : g_word
        pcmu_word_lane u_lane (
            .dstWord (bus.dstVal[16*i +: 16]),
            .srcWord (bus.srcVal[16*i +: 16]),
            .product (prod[i]),
            .greater (wordGt[i])
        );
        assign bus.gtWord[16*i +: 16]   = {16{wordGt[i]}};
        assign bus.mulUpper[16*i +: 16] = prod[i][31:16];
        assign bus.mulLower[16*i +: 16] = prod[i][15:0];
    end
    for (genvar b = 0; b < 8; b++) begin : g_byte
        assign byteGt[b] = $signed(bus.dstVal[8*b +: 8]) > $signed(bus.srcVal[8*b +: 8]);
        assign bus.gtByte[8*b +: 8] = {8{byteGt[b]}};
    end
    for (genvar d = 0; d < 2; d++) begin : g_dword
        assign dwordGt[d] = $signed(bus.dstVal[32*d +: 32]) > $signed(bus.srcVal[32*d +: 32]);
        assign bus.gtDword[32*d +: 32] = {32{dwordGt[d]}};
        // plain 32-bit wrap: all-0x8000 inputs give 0x80000000, no saturation
        assign bus.mulSum[32*d +: 32] = prod[2*d] + prod[2*d+1];
    end
endmodule // pcmu_lanes

// ==== verilog/pcmu_unit.sv ====
// Purpose: packed compare, multiply and OR execution slice with fault checks
// Assumes: decode supplies opcode, operands and mode state in one cycle
// Notes:   one cycle latency; a fault suppresses the write-back
// Summary of operation
// - byte compare sets each signed-greater byte to FF, else zero.
// - word compare sets each signed-greater word to FFFF, else zero.
// - dword compare sets each signed-greater dword to all ones, else zero.
// - destination is a packed register; source is register or 64-bit memory.
// - multiply-pair-sum adds low two products and high two products.
// - pair sum wraps to 80000000 when all words are 8000.
// - multiply-upper keeps bits 31..16 of each signed word product.
// - multiply-lower keeps bits 15..0, same for signed or unsigned.
// - OR combines all 64 bits of destination and source.
// - protected mode: bad segment address gives GP(0), stack gives SS(0).
// - protected mode: paging failure gives page fault with its code.
// - protected mode: unaligned operand faults only at privilege level 3.
// - emulation bit gives invalid opcode; task-switched gives not-available.
// - pending floating-point exception faults instead of executing.
// - real mode: operand byte beyond FFFF gives interrupt 13.
`timescale 1ns/10ps
`include "pcmu_params.svh"
module pcmu_unit (
    input  wire logic               clk_sys,
    input  wire logic               reset,
    input  wire logic               issueValid,
    input  wire logic [7:0]         opcodeByte,
    input  wire pcmu_pkg::pcmu_word_t dstValue,
    input  wire pcmu_pkg::pcmu_word_t srcValue,
    input  wire logic               srcIsMemory,
    input  wire logic               protectedMode,
    input  wire logic [1:0]         currentPrivilege,
    input  wire logic               emulationControlBit,
    input  wire logic               taskSwitchedBit,
    input  wire logic               floatErrorPending,
    input  wire logic               segmentAddrBad,
    input  wire logic               stackSegment,
    input  wire logic               pagingFail,
    input  wire logic [31:0]        pagingFaultCode,
    input  wire logic               memUnaligned,
    input  wire logic [31:0]        memOffset,
    output logic                    resultValid,
    output pcmu_pkg::pcmu_word_t    resultData,
    output logic                    faultValid,
    output pcmu_pkg::pcmu_fault_e   faultKind,
    output logic [7:0]              faultVector,
    output logic [31:0]             faultCode,
    output logic                    opIllegal
);
    import pcmu_pkg::*;

    pcmu_opnd_if opnd ();
    pcmu_op_e    opSel;
    pcmu_word_t  opResult;
    pcmu_fault_e faultSel;
    logic [7:0]  vectorSel;
    logic [32:0] lastByte;
    logic        memChecked;

    pcmu_word_t  resultData_q, resultData_d;
    logic        resultValid_q, resultValid_d;
    logic        faultValid_q, faultValid_d;
    pcmu_fault_e faultKind_q, faultKind_d;
    logic [7:0]  faultVector_q, faultVector_d;
    logic [31:0] faultCode_q, faultCode_d;
    logic        opIllegal_q, opIllegal_d;

    // ======================================================================
    // operand path: destination is always the register value; source may
    // already hold memory data, the unit does not care where it came from
    assign opnd.dstVal = dstValue;
    assign opnd.srcVal = srcValue;

    pcmu_lanes u_lanes (
        .bus (opnd.lanes)
    );

    // ======================================================================
    // opcode decode
    assign opSel = (opcodeByte == `PCMU_OP_GT_BYTE)   ? PCMU_OP_GTB  :
                   (opcodeByte == `PCMU_OP_GT_WORD)   ? PCMU_OP_GTW  :
                   (opcodeByte == `PCMU_OP_GT_DWORD)  ? PCMU_OP_GTD  :
                   (opcodeByte == `PCMU_OP_MUL_SUM)   ? PCMU_OP_MSUM :
                   (opcodeByte == `PCMU_OP_MUL_UPPER) ? PCMU_OP_MUPP :
                   (opcodeByte == `PCMU_OP_MUL_LOWER) ? PCMU_OP_MLOW :
                   (opcodeByte == `PCMU_OP_OR)        ? PCMU_OP_BOR  :
                   PCMU_OP_NONE;

    // result select per operation
    assign opResult = (opSel == PCMU_OP_GTB)  ? opnd.gtByte   :
                      (opSel == PCMU_OP_GTW)  ? opnd.gtWord   :
                      (opSel == PCMU_OP_GTD)  ? opnd.gtDword  :
                      (opSel == PCMU_OP_MSUM) ? opnd.mulSum   :
                      (opSel == PCMU_OP_MUPP) ? opnd.mulUpper :
                      (opSel == PCMU_OP_MLOW) ? opnd.mulLower :
                      (opSel == PCMU_OP_BOR)  ? (dstValue | srcValue) :
                      `PCMU_RESULT_RESET;

    // ======================================================================
    // fault checks; mode-wide faults first, then memory operand checks.
    // real-mode limit looks at the last byte of the 8-byte operand, so a
    // wrap past FFFF cannot hide behind a small start offset
    assign lastByte   = {1'b0, memOffset} + {1'b0, `PCMU_OPND_BYTES} - 33'h0_0000_0001;
    assign memChecked = srcIsMemory;

    assign faultSel =
        emulationControlBit                    ? PCMU_FLT_UD    :
        taskSwitchedBit                        ? PCMU_FLT_NM    :
        floatErrorPending                      ? PCMU_FLT_MF    :
        (memChecked && !protectedMode &&
         (lastByte > {1'b0, `PCMU_REAL_LIMIT})) ? PCMU_FLT_INT13 :
        (memChecked && protectedMode && segmentAddrBad &&
         stackSegment)                         ? PCMU_FLT_SS    :
        (memChecked && protectedMode &&
         segmentAddrBad)                       ? PCMU_FLT_GP    :
        (memChecked && protectedMode && pagingFail) ? PCMU_FLT_PF :
        (memChecked && protectedMode && memUnaligned &&
         (currentPrivilege == `PCMU_USER_CPL)) ? PCMU_FLT_AC    :
        PCMU_FLT_NONE;

    assign vectorSel = (faultSel == PCMU_FLT_UD)    ? `PCMU_VEC_UD :
                       (faultSel == PCMU_FLT_NM)    ? `PCMU_VEC_NM :
                       (faultSel == PCMU_FLT_MF)    ? `PCMU_VEC_MF :
                       (faultSel == PCMU_FLT_INT13) ? `PCMU_VEC_GP :
                       (faultSel == PCMU_FLT_SS)    ? `PCMU_VEC_SS :
                       (faultSel == PCMU_FLT_GP)    ? `PCMU_VEC_GP :
                       (faultSel == PCMU_FLT_PF)    ? `PCMU_VEC_PF :
                       (faultSel == PCMU_FLT_AC)    ? `PCMU_VEC_AC :
                       8'h00;

    // ======================================================================
    // next-state: a fault blocks the write-back so the register stays intact
    always_comb begin
        resultValid_d = issueValid && (opSel != PCMU_OP_NONE) && (faultSel == PCMU_FLT_NONE);
        resultData_d  = resultValid_d ? opResult : resultData_q;
        faultValid_d  = issueValid && (opSel != PCMU_OP_NONE) && (faultSel != PCMU_FLT_NONE);
        faultKind_d   = faultValid_d ? faultSel : PCMU_FLT_NONE;
        faultVector_d = faultValid_d ? vectorSel : 8'h00;
        // GP and SS carry code zero; page fault carries its own code
        faultCode_d   = (faultValid_d && faultSel == PCMU_FLT_PF) ? pagingFaultCode
                                                                  : 32'h0000_0000;
        opIllegal_d   = issueValid && (opSel == PCMU_OP_NONE);
    end

    // registered outputs
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            resultData_q  <= `PCMU_RESULT_RESET;
            resultValid_q <= 1'b0;
            faultValid_q  <= 1'b0;
            faultKind_q   <= PCMU_FLT_NONE;
            faultVector_q <= 8'h00;
            faultCode_q   <= 32'h0000_0000;
            opIllegal_q   <= 1'b0;
        end else begin
            resultData_q  <= resultData_d;
            resultValid_q <= resultValid_d;
            faultValid_q  <= faultValid_d;
            faultKind_q   <= faultKind_d;
            faultVector_q <= faultVector_d;
            faultCode_q   <= faultCode_d;
            opIllegal_q   <= opIllegal_d;
        end
    end

    assign resultData  = resultData_q;
    assign resultValid = resultValid_q;
    assign faultValid  = faultValid_q;
    assign faultKind   = faultKind_q;
    assign faultVector = faultVector_q;
    assign faultCode   = faultCode_q;
    assign opIllegal   = opIllegal_q;

    // ======================================================================
    // checks
    a_or_result: assert property (@(posedge clk_sys) disable iff (reset)
        issueValid && opSel == PCMU_OP_BOR && faultSel == PCMU_FLT_NONE
        |=> resultValid && resultData == ($past(dstValue) | $past(srcValue)))
        else $error("or result mismatch");

    a_gtb_lane0: assert property (@(posedge clk_sys) disable iff (reset)
        issueValid && opSel == PCMU_OP_GTB && faultSel == PCMU_FLT_NONE
        |=> resultData[7:0] ==
            (($signed($past(dstValue[7:0])) > $signed($past(srcValue[7:0]))) ? 8'hFF : 8'h00))
        else $error("byte compare lane wrong");

    a_gtw_lane3: assert property (@(posedge clk_sys) disable iff (reset)
        issueValid && opSel == PCMU_OP_GTW && faultSel == PCMU_FLT_NONE
        |=> resultData[63:48] == (($signed($past(dstValue[63:48])) >
            $signed($past(srcValue[63:48]))) ? 16'hFFFF : 16'h0000))
        else $error("word compare lane wrong");

    a_gtd_upper: assert property (@(posedge clk_sys) disable iff (reset)
        issueValid && opSel == PCMU_OP_GTD && faultSel == PCMU_FLT_NONE
        |=> resultData[63:32] == (($signed($past(dstValue[63:32])) >
            $signed($past(srcValue[63:32]))) ? 32'hFFFF_FFFF : 32'h0000_0000))
        else $error("dword compare wrong");

    a_sum_wrap: assert property (@(posedge clk_sys) disable iff (reset)
        issueValid && opSel == PCMU_OP_MSUM && faultSel == PCMU_FLT_NONE &&
        dstValue == 64'h8000_8000_8000_8000 && srcValue == 64'h8000_8000_8000_8000
        |=> resultData == 64'h8000_0000_8000_0000)
        else $error("pair sum did not wrap");

    a_low_lane0: assert property (@(posedge clk_sys) disable iff (reset)
        issueValid && opSel == PCMU_OP_MLOW && faultSel == PCMU_FLT_NONE
        |=> resultData[15:0] == 16'($past(dstValue[15:0]) * $past(srcValue[15:0])))
        else $error("lower product wrong");

    a_fault_nowrite: assert property (@(posedge clk_sys) disable iff (reset)
        issueValid && emulationControlBit && opSel != PCMU_OP_NONE
        |=> faultValid && faultKind == PCMU_FLT_UD && !resultValid && $stable(resultData))
        else $error("emulation bit did not fault");

    a_ac_priv: assert property (@(posedge clk_sys) disable iff (reset)
        faultValid && faultKind == PCMU_FLT_AC
        |-> $past(currentPrivilege) == 2'h3 && $past(protectedMode))
        else $error("alignment fault outside level 3");

    a_pf_code: assert property (@(posedge clk_sys) disable iff (reset)
        faultValid && faultKind == PCMU_FLT_PF |-> faultCode == $past(pagingFaultCode))
        else $error("page fault code lost");
endmodule // pcmu_unit

// ==== testbench/pcmu_issue_model.sv ====
// Purpose: decode and operand fetch side that feeds the unit
// Assumes: tasks are called just after a falling clock edge
// Notes:   released operand lines show inverted values; two releases in a row restore the last ones
`timescale 1ns/10ps
module pcmu_issue_model
    import pcmu_pkg::*;
(
    output logic        issueValid,
    output logic [7:0]  opcodeByte,
    output pcmu_word_t  dstValue,
    output pcmu_word_t  srcValue,
    output logic        srcIsMemory,
    output logic        protectedMode,
    output logic [1:0]  currentPrivilege,
    output logic        emulationControlBit,
    output logic        taskSwitchedBit,
    output logic        floatErrorPending,
    output logic        segmentAddrBad,
    output logic        stackSegment,
    output logic        pagingFail,
    output logic [31:0] pagingFaultCode,
    output logic        memUnaligned,
    output logic [31:0] memOffset
);
    // ======================================================================
    // all lines quiet at time zero so the unit never sees unknowns
    initial begin
        {issueValid, opcodeByte, dstValue, srcValue, memOffset, pagingFaultCode} = '0;
        {srcIsMemory, protectedMode, currentPrivilege, emulationControlBit, taskSwitchedBit,
         floatErrorPending, segmentAddrBad, stackSegment, pagingFail, memUnaligned} = '0;
    end

    // ======================================================================
    // one issue: ctl packs memory, mode, privilege and the fault inputs
    task automatic send(input logic [7:0] op, input pcmu_word_t d, input pcmu_word_t s,
                        input logic [10:0] c, input logic [31:0] pc, input logic [31:0] off);
        issueValid = 1'b1;
        opcodeByte = op;
        dstValue = d;
        srcValue = s;
        {srcIsMemory, protectedMode, currentPrivilege, emulationControlBit, taskSwitchedBit,
         floatErrorPending, segmentAddrBad, stackSegment, pagingFail, memUnaligned} = c;
        pagingFaultCode = pc;
        memOffset = off;
    endtask

    // released lines flip, so after a single release a stale value cannot pass for a held one
    task automatic idle();
        issueValid = 1'b0;
        opcodeByte = ~opcodeByte;
        dstValue = ~dstValue;
        srcValue = ~srcValue;
        memOffset = ~memOffset;
        pagingFaultCode = ~pagingFaultCode;
    endtask
endmodule // pcmu_issue_model

// ==== testbench/packed_compare_multiply_or_unit_tb_top.sv ====
// Purpose: self-checking bench for the packed compare / multiply / or unit
// Assumes: one-cycle answer, faults keep the last good result
// Notes:   each step's falling edge checks the previous issue and drives the next; reset edges check nothing
`timescale 1ns/10ps
`include "pcmu_params.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module packed_compare_multiply_or_unit_tb_top;
    import pcmu_pkg::*;
    logic clk_sys, reset = 1'b1, issueValid, srcIsMemory, protectedMode;
    logic emulationControlBit, taskSwitchedBit, floatErrorPending, segmentAddrBad;
    logic stackSegment, pagingFail, memUnaligned, resultValid, faultValid, opIllegal;
    logic [7:0] opcodeByte, faultVector, pOp;
    logic [1:0] currentPrivilege;
    logic [31:0] pagingFaultCode, memOffset, faultCode;
    pcmu_word_t dstValue, srcValue, resultData, expData;
    pcmu_fault_e faultKind;
    logic expV, expF, expI;
    logic [43:0] expFlt;
    int num_errors = 0, check_count = 0, seed = 12802;
    logic [7:0] opTab[8] = '{8'h64, 8'h65, 8'h66, 8'hF5, 8'hE5, 8'hD5, 8'hEB, 8'h74};
    pcmu_word_t dTab[3] = '{64'h8000_8000_8000_8000, 64'h7F80_0001_7FFF_FFFF, '1};
    pcmu_word_t sTab[3] = '{64'h8000_8000_8000_8000, 64'h807F_FFFF_8000_0000, '0};
    logic [10:0] fCtl[13] = '{11'h040, 11'h060, 11'h020, 11'h030, 11'h010, 11'h400,
                              11'h400, 11'h608, 11'h60C, 11'h602, 11'h781, 11'h701, 11'h208};

    pcmu_issue_model fe (.issueValid, .opcodeByte, .dstValue, .srcValue, .srcIsMemory,
        .protectedMode, .currentPrivilege, .emulationControlBit, .taskSwitchedBit,
        .floatErrorPending, .segmentAddrBad, .stackSegment, .pagingFail, .pagingFaultCode,
        .memUnaligned, .memOffset);
    pcmu_unit dut (.clk_sys, .reset, .issueValid, .opcodeByte, .dstValue, .srcValue,
        .srcIsMemory, .protectedMode, .currentPrivilege, .emulationControlBit,
        .taskSwitchedBit, .floatErrorPending, .segmentAddrBad, .stackSegment, .pagingFail,
        .pagingFaultCode, .memUnaligned, .memOffset, .resultValid, .resultData, .faultValid,
        .faultKind, .faultVector, .faultCode, .opIllegal);

    // ======================================================================
    // 50 MHz clock and a hang guard far beyond the run length
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    initial begin
        #1_000_000;
        num_errors++;
        finish_test();
    end

    // ======================================================================
    // reference arithmetic, element by element with plain integers
    function automatic pcmu_word_t model(logic [7:0] op, pcmu_word_t d, pcmu_word_t s);
        pcmu_word_t r;
        int p;
        r = (op == 8'hEB) ? (d | s) : '0;
        for (int i = 0; i < 8; i++) if (op == 8'h64 && $signed(d[8*i+:8]) > $signed(s[8*i+:8]))
            r[8*i+:8] = 8'hFF;
        for (int i = 0; i < 2; i++) if (op == 8'h66 && $signed(d[32*i+:32]) > $signed(s[32*i+:32]))
            r[32*i+:32] = 32'hFFFF_FFFF;
        for (int i = 0; i < 4; i++) begin
            p = $signed(d[16*i+:16]) * $signed(s[16*i+:16]);
            if (op == 8'h65 && $signed(d[16*i+:16]) > $signed(s[16*i+:16])) r[16*i+:16] = '1;
            if (op == 8'hE5) r[16*i+:16] = p[31:16];
            if (op == 8'hD5) r[16*i+:16] = p[15:0];
            if (op == 8'hF5) r[32*(i/2)+:32] = r[32*(i/2)+:32] + p;
        end
        return r;
    endfunction

    // fault kind, vector and code in the chosen priority order
    function automatic logic [43:0] fault_of(logic [10:0] c, logic [31:0] pc, logic [31:0] o);
        if (c[6]) return {PCMU_FLT_UD, `PCMU_VEC_UD, 32'h0000_0000};
        if (c[5]) return {PCMU_FLT_NM, `PCMU_VEC_NM, 32'h0000_0000};
        if (c[4]) return {PCMU_FLT_MF, `PCMU_VEC_MF, 32'h0000_0000};
        if (c[10] && !c[9] && {1'b0, o} + 33'h7 > 33'h0_FFFF)
            return {PCMU_FLT_INT13, `PCMU_VEC_GP, 32'h0000_0000};
        if (c[10] && c[9] && c[3])
            return c[2] ? {PCMU_FLT_SS, `PCMU_VEC_SS, 32'h0} : {PCMU_FLT_GP, `PCMU_VEC_GP, 32'h0};
        if (c[10] && c[9] && c[1]) return {PCMU_FLT_PF, `PCMU_VEC_PF, pc};
        if (c[10] && c[9] && c[0] && c[8:7] == 2'h3)
            return {PCMU_FLT_AC, `PCMU_VEC_AC, 32'h0000_0000};
        return {PCMU_FLT_NONE, 40'h00_0000_0000};
    endfunction

    function automatic pcmu_word_t rnd64();
        return {$random(seed), $random(seed)};
    endfunction

    // ======================================================================
    // compare what the previous issue should have produced
    task automatic check_out();
        `CHK("resultValid", expV, resultValid)
        `CHK("faultValid", expF, faultValid)
        `CHK("opIllegal", expI, opIllegal)
        `CHK("faultKind", expFlt[43:40], faultKind)
        `CHK("faultVector", expFlt[39:32], faultVector)
        `CHK("faultCode", expFlt[31:0], faultCode)
        case (pOp)
            8'h64: `CHK("gtByte", expData, resultData)
            8'h65: `CHK("gtWord", expData, resultData)
            8'h66: `CHK("gtDword", expData, resultData)
            8'hF5: `CHK("pairSum", expData, resultData)
            8'hE5: `CHK("mulUpper", expData, resultData)
            8'hD5: `CHK("mulLower", expData, resultData)
            8'hEB: `CHK("orData", expData, resultData)
            default: `CHK("keptData", expData, resultData)
        endcase
    endtask

    // one cycle: check, drive the next issue or idle, predict its answer
    task automatic step(input bit v, input logic [7:0] op, input pcmu_word_t d,
                        input pcmu_word_t s, input logic [10:0] c, input logic [31:0] off);
        logic [31:0] pc;
        pc = $random(seed);
        check_out();
        if (v) fe.send(op, d, s, c, pc, off);
        else fe.idle();
        {expV, expF, expI, pOp} = '0;
        expFlt = {PCMU_FLT_NONE, 40'h00_0000_0000};
        if (v && !(op inside {8'h64, 8'h65, 8'h66, 8'hF5, 8'hE5, 8'hD5, 8'hEB})) expI = 1'b1;
        else if (v) begin
            expFlt = fault_of(c, pc, off);
            expF = (expFlt[43:40] != PCMU_FLT_NONE);
            expV = !expF;
            if (expV) pOp = op;
            if (expV) expData = model(op, d, s);
        end
        @(negedge clk_sys);
    endtask

    task automatic do_reset(input int n);
        reset = 1'b1;
        fe.idle();
        repeat (n) @(negedge clk_sys);
        reset = 1'b0;
        {expV, expF, expI, pOp} = '0;
        expData = `PCMU_RESULT_RESET;
        expFlt = {PCMU_FLT_NONE, 40'h00_0000_0000};
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ======================================================================
    // main sequence: boundaries, faults, random traffic, reset mid-run
    initial begin
        @(negedge clk_sys);
        do_reset(2);
        for (int k = 0; k < 21; k++) step(1, opTab[k%7], dTab[k/7], sTab[k/7], 11'h000, 0);
        for (int k = 0; k < 13; k++)
            step(1, opTab[k%7], rnd64(), rnd64(), fCtl[k], (k == 6) ? 32'h0000_FFF9 : 32'h0000_FFF8);
        step(1, 8'h74, rnd64(), rnd64(), 11'h040, 0);
        for (int k = 0; k < 400; k++)
            step($random(seed) % 4 != 0, opTab[$unsigned($random(seed)) % 8], rnd64(), rnd64(),
                 11'($random(seed)) & {4'hF, 3'($random(seed) & $random(seed)), 4'hF},
                 $random(seed) & 32'h0001_FFFF);
        step(0, 8'h00, '0, '0, 11'h000, 0);
        do_reset(1);
        step(1, 8'hEB, rnd64(), rnd64(), 11'h000, 0);
        step(0, 8'h00, '0, '0, 11'h000, 0);
        check_out();
        finish_test();
    end
endmodule // packed_compare_multiply_or_unit_tb_top
